// file: rtl/drcmux_top.sv
// Purpose: DRAM address multiplexer with row/column strobe sequencing.
// Assumes: Request inputs come from logic on sys_clk; bank types static.
// Notes: Address lines change only while the column strobe is high.
//   Requests are not queued: one raised while ready is low waits.
//   Strobe timing is fixed at this clock; retune it in the package.
`timescale 1ns/1ps
module drcmux_top (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic req,
  input wire logic [drcmux_pkg::HADDR_W-1:0] req_addr,
  input wire logic [drcmux_pkg::BANK_W-1:0] req_bank,
  input wire logic [drcmux_pkg::NUM_BANKS*drcmux_pkg::TYPE_W-1:0] bank_type,
  input wire logic page_mode_en,
  output logic ready,
  output logic done,
  output logic type_err,
  output logic phase_is_row,
  output logic [drcmux_pkg::NUM_BANKS-1:0] row_strobe_n,
  output logic col_strobe_n,
  output logic [drcmux_pkg::LINE_W-1:0] multiplexed_dram_address,
  output logic [drcmux_pkg::GEOM_W-1:0] refresh_rows_log2
);
  import drcmux_pkg::*;

  // Access sequencer states
  typedef enum logic [2:0] {
    S_IDLE,       // No row open, waiting for a request
    S_ROW_SET,    // Row address on lines, strobes still high
    S_ROW_HOLD,   // Row strobe low, waiting out row-to-column delay
    S_COL_SET,    // Column address on lines, column strobe high
    S_COL_ACT,    // Column strobe low
    S_PAGE_OPEN,  // Row held open for page hits
    S_PRECH       // All row strobes high, precharge wait
  } drcmux_state_t;

  // Sequencer state
  drcmux_state_t st_r;
  drcmux_state_t st_nxt;
  // Wait counter for strobe timing
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  // Latched row and column line patterns of the current access
  logic [LINE_W-1:0] row_lat_r;
  logic [LINE_W-1:0] row_lat_nxt;
  logic [LINE_W-1:0] col_lat_r;
  logic [LINE_W-1:0] col_lat_nxt;
  // Bank of the current access
  logic [BANK_W-1:0] bank_r;
  logic [BANK_W-1:0] bank_nxt;
  // A page miss is waiting for the precharge to finish
  logic pend_r;
  logic pend_nxt;
  // Registered outputs
  logic ready_r;
  logic ready_nxt;
  logic done_r;
  logic done_nxt;
  logic err_r;
  logic err_nxt;
  logic phase_row_r;
  logic phase_row_nxt;
  logic [NUM_BANKS-1:0] rstb_r;
  logic [NUM_BANKS-1:0] rstb_nxt;
  logic cstb_r;
  logic cstb_nxt;
  logic [LINE_W-1:0] lines_r;
  logic [LINE_W-1:0] lines_nxt;
  logic [GEOM_W-1:0] rfsh_r;
  logic [GEOM_W-1:0] rfsh_nxt;

  // Type code of the requested bank
  logic [TYPE_W-1:0] req_type;
  // Geometry of the requested bank
  logic [GEOM_W-1:0] req_col_w;
  logic [GEOM_W-1:0] req_row_w;
  logic [GEOM_W-1:0] req_rfsh;
  logic req_type_ok;
  // Mapped line patterns of the incoming request
  logic [LINE_W-1:0] req_col_lines;
  logic [LINE_W-1:0] req_row_lines;
  // Request taken this cycle
  logic take;
  // Incoming request hits the open row of the open bank
  logic page_hit;

  // Per-bank type select; the bank configuration is static
  assign req_type = bank_type[req_bank * TYPE_W +: TYPE_W];

  // Density and page organisation decode for the requested bank
  drcmux_geom u_geom (
    .type_code (req_type),
    .col_w (req_col_w),
    .row_w (req_row_w),
    .rfsh_log2 (req_rfsh),
    .type_ok (req_type_ok)
  );

  // Address bit placement for both phases
  drcmux_map u_map (
    .addr (req_addr),
    .col_w (req_col_w),
    .row_w (req_row_w),
    .col_lines (req_col_lines),
    .row_lines (req_row_lines)
  );

  // Requests are only looked at while ready is shown
  assign take = req && ready_r;
  // Row compare uses the mapped lines, so unused bits never mismatch
  assign page_hit = (req_bank == bank_r) && (req_row_lines == row_lat_r);

  // Next-state logic of the sequencer and its outputs
  always_comb begin
    st_nxt = st_r;
    // Counter runs down and rests at zero between waits
    cnt_nxt = (cnt_r == CNT_RST) ? CNT_RST : cnt_r - 4'h1;
    row_lat_nxt = row_lat_r;
    col_lat_nxt = col_lat_r;
    bank_nxt = bank_r;
    pend_nxt = pend_r;
    done_nxt = 1'b0;
    err_nxt = 1'b0;
    phase_row_nxt = phase_row_r;
    rstb_nxt = rstb_r;
    cstb_nxt = 1'b1;
    lines_nxt = lines_r;
    rfsh_nxt = rfsh_r;
    unique case (st_r)
      // Idle: a legal request starts with the row phase
      S_IDLE: begin
        if (take && !req_type_ok) begin
          // Illegal type: answer at once, no strobes
          done_nxt = 1'b1;
          err_nxt = 1'b1;
        end else if (take) begin
          row_lat_nxt = req_row_lines;
          col_lat_nxt = req_col_lines;
          bank_nxt = req_bank;
          rfsh_nxt = req_rfsh;
          // Row pattern goes out a cycle ahead of its strobe
          lines_nxt = req_row_lines;
          phase_row_nxt = 1'b1;
          st_nxt = S_ROW_SET;
        end
      end
      // Row address stable: drop the strobe of the chosen bank
      S_ROW_SET: begin
        rstb_nxt[bank_r] = 1'b0;
        cnt_nxt = RCD_LOAD;
        st_nxt = S_ROW_HOLD;
      end
      // Hold row lines until the row-to-column delay runs out
      S_ROW_HOLD: begin
        if (cnt_r == CNT_RST) begin
          // Switch to column lines while the column strobe is high
          lines_nxt = col_lat_r;
          phase_row_nxt = 1'b0;
          st_nxt = S_COL_SET;
        end
      end
      // Column lines stable for a cycle, then column strobe low
      S_COL_SET: begin
        cstb_nxt = 1'b0;
        cnt_nxt = CAS_LOAD;
        st_nxt = S_COL_ACT;
      end
      // Column strobe held low for its minimum width
      S_COL_ACT: begin
        if (cnt_r == CNT_RST) begin
          done_nxt = 1'b1;
          if (page_mode_en) begin
            // Keep the row open for following hits
            st_nxt = S_PAGE_OPEN;
          end else begin
            // Close the row at once
            rstb_nxt = RSTROBE_RST;
            cnt_nxt = RP_LOAD;
            st_nxt = S_PRECH;
          end
        end else begin
          cstb_nxt = 1'b0;
        end
      end
      // Row open: hits go straight to a column cycle
      S_PAGE_OPEN: begin
        if (take && !req_type_ok) begin
          // Illegal type: refuse, leave the open row alone
          done_nxt = 1'b1;
          err_nxt = 1'b1;
        end else if (take && page_hit) begin
          col_lat_nxt = req_col_lines;
          lines_nxt = req_col_lines;
          st_nxt = S_COL_SET;
        end else if (take) begin
          // Miss: remember the request, precharge first
          row_lat_nxt = req_row_lines;
          col_lat_nxt = req_col_lines;
          bank_nxt = req_bank;
          rfsh_nxt = req_rfsh;
          pend_nxt = 1'b1;
          rstb_nxt = RSTROBE_RST;
          cnt_nxt = RP_LOAD;
          st_nxt = S_PRECH;
        end else if (!page_mode_en) begin
          // Page mode withdrawn: close the row
          rstb_nxt = RSTROBE_RST;
          cnt_nxt = RP_LOAD;
          st_nxt = S_PRECH;
        end
      end
      // Precharge: strobes high, then serve a pending miss or idle
      S_PRECH: begin
        if (cnt_r == CNT_RST) begin
          if (pend_r) begin
            pend_nxt = 1'b0;
            lines_nxt = row_lat_r;
            phase_row_nxt = 1'b1;
            st_nxt = S_ROW_SET;
          end else begin
            st_nxt = S_IDLE;
          end
        end
      end
    endcase
    // Ready only in states that take a request; it is worked out
    // from the next state so that it never lags the sequencer by a
    // cycle and a busy state can never take a request
    ready_nxt = (st_nxt == S_IDLE) || (st_nxt == S_PAGE_OPEN);
  end

  // Registers of the sequencer; constants only under reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= S_IDLE;
      cnt_r <= CNT_RST;
      row_lat_r <= LINES_RST;
      col_lat_r <= LINES_RST;
      bank_r <= '0;
      pend_r <= 1'b0;
      ready_r <= 1'b1;
      done_r <= 1'b0;
      err_r <= 1'b0;
      phase_row_r <= 1'b0;
      rstb_r <= RSTROBE_RST;
      cstb_r <= 1'b1;
      lines_r <= LINES_RST;
      rfsh_r <= GEOM_RST;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      row_lat_r <= row_lat_nxt;
      col_lat_r <= col_lat_nxt;
      bank_r <= bank_nxt;
      pend_r <= pend_nxt;
      ready_r <= ready_nxt;
      done_r <= done_nxt;
      err_r <= err_nxt;
      phase_row_r <= phase_row_nxt;
      rstb_r <= rstb_nxt;
      cstb_r <= cstb_nxt;
      lines_r <= lines_nxt;
      rfsh_r <= rfsh_nxt;
    end
  end

  // Every output comes straight from a flip-flop, so the DRAM side
  // never sees decode glitches on strobes or lines
  // Handshake towards the host-side controller
  assign ready = ready_r;
  // One-cycle finish pulse, refusals included
  assign done = done_r;
  // Pulses together with done for an illegal bank type
  assign type_err = err_r;
  // Tells which pattern the lines carry
  assign phase_is_row = phase_row_r;
  // Strobes; all high in idle and during precharge; an open page keeps its row strobe low
  assign row_strobe_n = rstb_r;
  assign col_strobe_n = cstb_r;
  // Mapped lines; the per-type layouts come from the geometry
  // decoder and the mapper instantiated above
  assign multiplexed_dram_address = lines_r;
  // Refresh row count of the bank last accepted
  assign refresh_rows_log2 = rfsh_r;

endmodule : drcmux_top

// file: rtl/drcmux_pkg.sv
// Purpose: Shared constants for the DRAM row/column address multiplexer.
// Assumes: 250 MHz system clock, four banks, twelve multiplexed lines.
// Notes: Geometry tables are indexed by the per-bank device type code.
package drcmux_pkg;

  // Widths of the datapath
  localparam int unsigned LINE_W = 12;     // Multiplexed address lines
  localparam int unsigned HADDR_W = 26;    // Host byte address, A0..A25
  localparam int unsigned NUM_BANKS = 4;   // One row strobe per bank
  localparam int unsigned BANK_W = 2;      // Bank select width
  localparam int unsigned TYPE_W = 4;      // Device type code width
  localparam int unsigned GEOM_W = 4;      // Column/row width field
  localparam int unsigned CNT_W = 4;       // Wait counter width
  localparam int unsigned ADDR_LSB = 2;    // Lowest address bit mapped

  // Device type codes, one per density and page organisation
  localparam logic [3:0] TYPE_256K_P1 = 4'h0;
  localparam logic [3:0] TYPE_256K_P2 = 4'h1;
  localparam logic [3:0] TYPE_512K = 4'h2;
  localparam logic [3:0] TYPE_1M_P1 = 4'h3;
  localparam logic [3:0] TYPE_1M_P2 = 4'h4;
  localparam logic [3:0] TYPE_1M_P3 = 4'h5;
  localparam logic [3:0] TYPE_2M_P1 = 4'h6;
  localparam logic [3:0] TYPE_2M_P2 = 4'h7;
  localparam logic [3:0] TYPE_4M_P1 = 4'h8;
  localparam logic [3:0] TYPE_4M_P2 = 4'h9;
  localparam logic [3:0] TYPE_8M = 4'ha;
  localparam logic [3:0] TYPE_16M = 4'hb;
  localparam int unsigned NUM_TYPES = 12;  // Codes at or above this are illegal

  // Column lines used per type code
  localparam logic [3:0] COL_W_TAB [NUM_TYPES] = '{
    4'h9, 4'h8, 4'h9, 4'ha, 4'h9, 4'h8, 4'ha, 4'h9, 4'hb, 4'ha, 4'hb, 4'hc};
  // Row lines used per type code
  localparam logic [3:0] ROW_W_TAB [NUM_TYPES] = '{
    4'h9, 4'ha, 4'ha, 4'ha, 4'hb, 4'hc, 4'hb, 4'ha, 4'hb, 4'hc, 4'hc, 4'hc};
  // Log2 of refresh row count per type code
  localparam logic [3:0] RFSH_LOG2_TAB [NUM_TYPES] = '{
    4'h9, 4'ha, 4'ha, 4'ha, 4'hb, 4'hc, 4'hb, 4'hc, 4'hb, 4'hc, 4'hc, 4'hc};

  // Timing, figures in ns and derived cycle counts
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned T_RCD_NS = 20;   // Row strobe to column strobe
  localparam int unsigned T_CAS_NS = 15;   // Column strobe low time
  localparam int unsigned T_RP_NS = 30;    // Row precharge time
  localparam int unsigned RCD_CYC = (T_RCD_NS * 1000 + CLK_PERIOD_PS - 1)
                                    / CLK_PERIOD_PS;
  localparam int unsigned CAS_CYC = (T_CAS_NS * 1000 + CLK_PERIOD_PS - 1)
                                    / CLK_PERIOD_PS;
  localparam int unsigned RP_CYC = (T_RP_NS * 1000 + CLK_PERIOD_PS - 1)
                                   / CLK_PERIOD_PS;
  localparam logic [3:0] RCD_LOAD = 4'(RCD_CYC - 1);
  localparam logic [3:0] CAS_LOAD = 4'(CAS_CYC - 1);
  localparam logic [3:0] RP_LOAD = 4'(RP_CYC - 1);

  // Values after reset
  localparam logic [11:0] LINES_RST = 12'h000;
  localparam logic [3:0] RSTROBE_RST = 4'hf;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [3:0] GEOM_RST = 4'h0;

endpackage : drcmux_pkg

// file: rtl/drcmux_geom.sv
// Purpose: Decode a device type code into column, row and refresh widths.
// Assumes: Codes at or above the type count are illegal.
// Notes: Illegal codes give zero widths so every line stays low.
`timescale 1ns/1ps
module drcmux_geom (
  input wire logic [drcmux_pkg::TYPE_W-1:0] type_code,
  output logic [drcmux_pkg::GEOM_W-1:0] col_w,
  output logic [drcmux_pkg::GEOM_W-1:0] row_w,
  output logic [drcmux_pkg::GEOM_W-1:0] rfsh_log2,
  output logic type_ok
);
  import drcmux_pkg::*;

  // Table lookup; the range check guards the array index
  always_comb begin
    type_ok = (32'(type_code) < NUM_TYPES);
    col_w = GEOM_RST;
    row_w = GEOM_RST;
    rfsh_log2 = GEOM_RST;
    if (type_ok) begin
      col_w = COL_W_TAB[type_code];
      row_w = ROW_W_TAB[type_code];
      rfsh_log2 = RFSH_LOG2_TAB[type_code];
    end
  end

endmodule : drcmux_geom

// file: rtl/drcmux_map.sv
// Purpose: Map host address bits onto the column and row line sets.
// Assumes: Column starts at A2, row starts right above the column.
// Notes: Lines above the selected width are forced low.
`timescale 1ns/1ps
module drcmux_map (
  input wire logic [drcmux_pkg::HADDR_W-1:0] addr,
  input wire logic [drcmux_pkg::GEOM_W-1:0] col_w,
  input wire logic [drcmux_pkg::GEOM_W-1:0] row_w,
  output logic [drcmux_pkg::LINE_W-1:0] col_lines,
  output logic [drcmux_pkg::LINE_W-1:0] row_lines
);
  import drcmux_pkg::*;

  // One slice per multiplexed line
  for (genvar i = 0; i < LINE_W; i++) begin : g_line
    // Row source index; never above 25 for legal widths
    logic [4:0] row_idx;
    assign row_idx = 5'(ADDR_LSB) + 5'(col_w) + 5'(i);
    // Column phase: Ai+2 on line i
    assign col_lines[i] = (i < col_w) ? addr[ADDR_LSB + i] : 1'b0;
    // Row phase: next bits above the column; unused lines low
    assign row_lines[i] = (i < row_w) ? addr[row_idx] : 1'b0;
  end

endmodule : drcmux_map

// file: verif/drcmux_dram_model.sv
// Purpose: Behavioural DRAM bank that latches row and column addresses.
// Assumes: Strobes are active low and latch on their falling edge.
// Notes: Holds no data; it only records what the lines carried.
`timescale 1ns/1ps
module drcmux_dram_model (
  input wire logic [3:0] row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic [11:0] lines,
  output logic [11:0] row_seen,
  output logic [11:0] col_seen
);
  wire logic any_row; // Low while some bank row is open
  assign any_row = &row_strobe_n;
  // Row address latched as a row strobe falls
  always @(negedge any_row) begin
    row_seen = lines;
  end
  // Column address latched as the column strobe falls
  always @(negedge col_strobe_n) begin
    col_seen = lines;
  end
endmodule : drcmux_dram_model

// file: verif/drcmux_chk.sv
// Purpose: Port-level timing checks on the address multiplexer.
// Assumes: One clock domain, reset active low.
// Notes: Bound to the top module below.
`timescale 1ns/1ps
module drcmux_chk (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic req,
  input wire logic [1:0] req_bank,
  input wire logic [15:0] bank_type,
  input wire logic page_mode_en,
  input wire logic ready,
  input wire logic done,
  input wire logic type_err,
  input wire logic phase_is_row,
  input wire logic [3:0] row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic [11:0] multiplexed_dram_address
);
  import drcmux_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [3:0] sel_type; // Type of the requested bank
  logic take_ok; // Legal request taken from idle
  logic take_bad; // Request to a bank of illegal type
  assign sel_type = bank_type[req_bank*4 +: 4];
  assign take_ok = req && ready && &row_strobe_n && (sel_type < 4'hc);
  assign take_bad = req && ready && (sel_type >= 4'hc);
  // Quiet stretch, then the finish pulse
  sequence quiet_then_done;
    !done[*8] ##[4:5] done;
  endsequence
  // Four low cycles then release
  sequence cas_pulse;
    !col_strobe_n[*4] ##1 col_strobe_n;
  endsequence
  err_with_done_a: assert property (type_err |-> done)
    else $error("type error without done");
  col_under_row_a: assert property (!col_strobe_n |->
    !(&row_strobe_n) && !phase_is_row)
    else $error("column strobe outside open row or in row phase");
  cas_width_a: assert property ($fell(col_strobe_n) |-> cas_pulse)
    else $error("column strobe width wrong");
  col_hold_a: assert property ($fell(col_strobe_n) |->
    $stable(multiplexed_dram_address)[*4])
    else $error("lines moved under column strobe");
  row_fall_a: assert property (
    (|(~row_strobe_n & $past(row_strobe_n)))
    |-> phase_is_row && $stable(multiplexed_dram_address))
    else $error("row strobe fell without settled row lines");
  done_time_a: assert property (take_ok |=> quiet_then_done)
    else $error("fresh access finished at wrong time");
  err_fast_a: assert property (take_bad |=>
    done && type_err && $stable(row_strobe_n))
    else $error("illegal type not refused next cycle");
  precharge_wait_a: assert property (done && !type_err
    && !page_mode_en |-> !ready[*8] ##1 ready)
    else $error("precharge length wrong");
  page_ready_a: assert property (done && !type_err && page_mode_en
    |-> ready)
    else $error("open page not ready with done");
endmodule : drcmux_chk
bind drcmux_top drcmux_chk drcmux_chk_inst (
  .sys_clk(sys_clk), .rst_n(rst_n), .req(req), .req_bank(req_bank),
  .bank_type(bank_type), .page_mode_en(page_mode_en), .ready(ready),
  .done(done), .type_err(type_err), .phase_is_row(phase_is_row),
  .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
  .multiplexed_dram_address(multiplexed_dram_address)
);

// file: verif/drcmux_top_test.sv
// Purpose: Self-checking bench for the DRAM address multiplexer.
// Assumes: Requests held until taken; one bank type change per idle gap.
// Notes: Widths below are kept apart from the design's own tables.
`timescale 1ns/1ps
module drcmux_top_test;
  import drcmux_pkg::*;
  logic sys_clk, rst_n, req, page_mode_en;
  logic [25:0] req_addr;
  logic [1:0] req_bank;
  logic [15:0] bank_type;
  logic ready, done, type_err, phase_is_row, col_strobe_n;
  logic [3:0] row_strobe_n, refresh_rows_log2;
  logic [11:0] mux_lines, row_seen, col_seen;
  int bad_count = 0;
  int compares = 0;
  logic err_r, rstb_r; // Flags seen with done
  // Column, row and refresh widths per type code
  logic [3:0] cw_t [12] = '{4'h9, 4'h8, 4'h9, 4'ha, 4'h9, 4'h8, 4'ha,
    4'h9, 4'hb, 4'ha, 4'hb, 4'hc};
  logic [3:0] rw_t [12] = '{4'h9, 4'ha, 4'ha, 4'ha, 4'hb, 4'hc, 4'hb,
    4'ha, 4'hb, 4'hc, 4'hc, 4'hc};
  logic [3:0] rf_t [12] = '{4'h9, 4'ha, 4'ha, 4'ha, 4'hb, 4'hc, 4'hb,
    4'hc, 4'hb, 4'hc, 4'hc, 4'hc};
  logic [25:0] pats [2] = '{26'h3ffffff, 26'h2a5c3b4};
  drcmux_top drcmux_top_inst (.sys_clk(sys_clk), .rst_n(rst_n), .req(req),
    .req_addr(req_addr), .req_bank(req_bank), .bank_type(bank_type),
    .page_mode_en(page_mode_en), .ready(ready), .done(done),
    .type_err(type_err), .phase_is_row(phase_is_row),
    .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
    .multiplexed_dram_address(mux_lines),
    .refresh_rows_log2(refresh_rows_log2));
  drcmux_dram_model drcmux_dram_model_inst (.row_strobe_n(row_strobe_n),
    .col_strobe_n(col_strobe_n), .lines(mux_lines), .row_seen(row_seen),
    .col_seen(col_seen));
  // Address bits from lo upward, w of them, rest low
  function automatic logic [11:0] field(logic [25:0] a, int lo,
    logic [3:0] w);
    field = 12'((a >> lo) & ((26'h1 << w) - 26'h1));
  endfunction : field
  // One comparison, counted
  task automatic chk(logic [11:0] got, logic [11:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Full access: hold the request until taken, then wait for done
  task automatic access(logic [3:0] t, logic [25:0] a, logic [1:0] b);
    int n;
    @(posedge sys_clk);
    bank_type[b*4 +: 4] <= t;
    @(posedge sys_clk);
    req <= 1'b1;
    req_addr <= a;
    req_bank <= b;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (ready !== 1'b1 && n < 100);
    if (n >= 100) chk(12'h0, 12'h1);
    req <= 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (done !== 1'b1 && n < 100);
    err_r = type_err;
    rstb_r = row_strobe_n[b];
    if (n >= 100) chk(12'h1, 12'h0);
  endtask : access
  // Every type, two address patterns, closed page
  task automatic test_maps();
    for (int t = 0; t < 12; t++) begin
      for (int p = 0; p < 2; p++) begin
        access(4'(t), pats[p], 2'(t));
        chk(col_seen, field(pats[p], 2, cw_t[t]));
        chk(row_seen, field(pats[p], 2 + cw_t[t], rw_t[t]));
        chk({8'h0, refresh_rows_log2}, {8'h0, rf_t[t]});
        chk({11'h0, err_r}, 12'h0);
        chk({11'h0, rstb_r}, 12'h1);
      end
    end
    $display("test maps done");
  endtask : test_maps
  // Illegal type is refused without a DRAM cycle
  task automatic test_illegal();
    for (int t = 12; t < 16; t++) begin
      access(4'(t), 26'h1234568, 2'h1);
      chk({11'h0, err_r}, 12'h1);
      chk({8'h0, row_strobe_n}, 12'h00f);
    end
    $display("test illegal done");
  endtask : test_illegal
  // Open page: hit keeps the row, miss reopens it
  task automatic test_page();
    page_mode_en <= 1'b1;
    access(4'h3, 26'h0aa5554, 2'h2);
    access(4'h3, 26'h0aa5ff8, 2'h2);
    chk(col_seen, field(26'h0aa5ff8, 2, 4'ha));
    chk(row_seen, field(26'h0aa5554, 12, 4'ha));
    chk({11'h0, rstb_r}, 12'h0);
    // Illegal bank while a row is open: refused, row of bank 2 kept
    access(4'hc, 26'h0aa5554, 2'h1);
    chk({11'h0, err_r}, 12'h1);
    chk({8'h0, row_strobe_n}, 12'h00b);
    access(4'h3, 26'h1551234, 2'h2);
    chk(row_seen, field(26'h1551234, 12, 4'ha));
    chk(col_seen, field(26'h1551234, 2, 4'ha));
    page_mode_en <= 1'b0;
    access(4'h3, 26'h1551234, 2'h2);
    chk({11'h0, rstb_r}, 12'h1);
    $display("test page done");
  endtask : test_page
  // Counts, verdict and end of run
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up
  // Clock, 4 ns period
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // Watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    wrap_up();
  end
  // Main sequence
  initial begin
    rst_n = 1'b0;
    req = 1'b0;
    req_addr = 26'h0;
    req_bank = 2'h0;
    bank_type = 16'h0;
    page_mode_en = 1'b0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    test_maps();
    test_illegal();
    test_page();
    wrap_up();
  end
endmodule : drcmux_top_test
